// *** logic/phy_port_select_config.v ***
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "phy_port_select_regs.vh"

module phy_port_select_config #(
    parameter TIMEOUT_CYCLES = `SOFT_RESET_TRIGGER_TIMEOUT_CYCLES
) (
    // System
    input  wire        clock,
    input  wire        rst,
    input  wire        clockEnable,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Interrupt
    output reg         irq,
    // MII clocks in
    input  wire        intRxClk,
    input  wire        intTxClk,
    input  wire        extRxClk,
    input  wire        extTxClk,
    // Routed MII clock selection and port enables
    output reg  [1:0]  miiClockRoute,
    output reg         internalPhyEnable,
    output reg         outsideMiiEnable,
    // Internal management port
    input  wire        intMdioIn,
    output reg         intMdioOut,
    output reg         intMdc,
    // External management port
    input  wire        extMdioIn,
    output reg         extMdioOut,
    output reg         extMdioOe,
    output reg         extMdc,
    // Management master from the controller
    input  wire        mgmtMdc,
    input  wire        mgmtMdioOut,
    input  wire        mgmtMdioOe,
    output reg         mgmtMdioIn,
    // Soft reset outputs
    output reg         softResetPulse,
    output reg         errorClear
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function isInternalSource;
        input [1:0] sel;
        begin
            isInternalSource = (sel == `CLKSRC_INTERNAL) || (sel == `CLKSRC_INTERNAL_ALT);
        end
    endfunction

    function [1:0] routeCode;
        input [1:0] sel;
        begin
            if (isInternalSource(sel)) begin
                routeCode = `CLKSRC_INTERNAL;
            end else begin
                routeCode = sel;
            end
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    localparam IDLE    = 2'h0;
    localparam PULSE   = 2'h1;
    localparam WAITCLK = 2'h2;

    reg  [1:0]  mii_clock_source_sel;
    reg         mgmt_port_target_sel;
    reg         outside_phy_strap_flag;
    reg         outside_mii_port_enable;
    reg         soft_reset_timeout_flag;
    reg         soft_reset_trigger;
    reg  [1:0]  resetState;
    reg  [31:0] waitCount;
    reg  [2:0]  pulseCount;
    reg  [1:0]  irqStatus;
    reg  [1:0]  irqEnable;
    reg  [2:0]  strapSync;
    reg  [2:0]  strapFill;
    reg         strapTaken;

    wire        intRxRunning;
    wire        intTxRunning;
    wire        phyClocksRunning = intRxRunning & intTxRunning;

    wire        access   = psel & penable & ~pready;
    wire        wrAccess = access & pwrite;
    wire        hitCfg   = paddr == `HWCFG_OFFSET;
    wire        hitStat  = paddr == `IRQ_STATUS_OFFSET;
    wire        hitEn    = paddr == `IRQ_ENABLE_OFFSET;
    wire        hitClr   = paddr == `IRQ_CLEAR_OFFSET;
    wire        mapped   = hitCfg | hitStat | hitEn | hitClr;
    wire        cfgWrite = wrAccess & hitCfg & (resetState == IDLE);
    wire        srstReq  = cfgWrite & pwdata[`SOFT_RESET_BIT];

    reg         timeoutEvent;
    reg         doneEvent;

    clock_activity_monitor monRx (
        .clock        (clock),
        .rst          (rst),
        .clockEnable  (clockEnable),
        .watchedClock (intRxClk),
        .running      (intRxRunning)
    );

    clock_activity_monitor monTx (
        .clock        (clock),
        .rst          (rst),
        .clockEnable  (clockEnable),
        .watchedClock (intTxClk),
        .running      (intTxRunning)
    );

    // ----------------------------------------
    // Strap capture after reset release
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            strapSync              <= 3'h0;
            strapFill              <= 3'h0;
            strapTaken             <= 1'b0;
            outside_phy_strap_flag <= 1'b0;
        end else if (clockEnable) begin
            strapSync <= {strapSync[1:0], extMdioIn};
            strapFill <= {strapFill[1:0], 1'b1};
            // Chain must hold pin samples, not reset zeros; feeds nothing else
            if (!strapTaken && strapFill[2] && strapSync[2] == strapSync[1]) begin
                outside_phy_strap_flag <= strapSync[2];
                strapTaken             <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Configuration and soft reset sequencer
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            mii_clock_source_sel    <= `CLKSRC_RESET;
            mgmt_port_target_sel    <= 1'b0;
            outside_mii_port_enable <= 1'b0;
            soft_reset_timeout_flag <= 1'b0;
            soft_reset_trigger      <= 1'b0;
            resetState              <= IDLE;
            waitCount               <= 32'h0;
            pulseCount              <= 3'h0;
            softResetPulse          <= 1'b0;
            errorClear              <= 1'b0;
            timeoutEvent            <= 1'b0;
            doneEvent               <= 1'b0;
        end else if (clockEnable) begin
            timeoutEvent <= 1'b0;
            doneEvent    <= 1'b0;
            errorClear   <= 1'b0;
            if (cfgWrite) begin
                mii_clock_source_sel    <= pwdata[`CLKSRC_HI:`CLKSRC_LO];
                mgmt_port_target_sel    <= pwdata[`MGMT_TARGET_BIT];
                outside_mii_port_enable <= pwdata[`EXT_ENABLE_BIT];
            end
            case (resetState)
                IDLE: begin
                    if (srstReq) begin
                        soft_reset_trigger      <= 1'b1;
                        soft_reset_timeout_flag <= 1'b0;
                        waitCount               <= 32'h0;
                        resetState              <= WAITCLK;
                    end
                end
                WAITCLK: begin
                    if (phyClocksRunning) begin
                        softResetPulse <= 1'b1;
                        errorClear     <= 1'b1;
                        pulseCount     <= 3'h0;
                        resetState     <= PULSE;
                    end else if (waitCount >= TIMEOUT_CYCLES - 1) begin
                        // Abandon; clock source, management target and port enable fields are left untouched
                        soft_reset_timeout_flag <= 1'b1;
                        soft_reset_trigger      <= 1'b0;
                        timeoutEvent            <= 1'b1;
                        resetState              <= IDLE;
                    end else begin
                        waitCount <= waitCount + 32'h1;
                    end
                end
                PULSE: begin
                    if (pulseCount == `SOFT_RESET_TRIGGER_PULSE_CYCLES - 1) begin
                        softResetPulse          <= 1'b0;
                        soft_reset_trigger      <= 1'b0;
                        mii_clock_source_sel    <= `CLKSRC_RESET;
                        mgmt_port_target_sel    <= 1'b0;
                        outside_mii_port_enable <= 1'b0;
                        doneEvent               <= 1'b1;
                        resetState              <= IDLE;
                    end else begin
                        pulseCount <= pulseCount + 3'h1;
                    end
                end
                default: begin
                    resetState <= IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Interrupts; set wins over clear
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStatus <= 2'h0;
            irqEnable <= 2'h0;
            irq       <= 1'b0;
        end else if (clockEnable) begin
            if (wrAccess && hitEn) begin
                irqEnable <= pwdata[1:0];
            end
            irqStatus <= (irqStatus & ~((wrAccess && hitClr) ? pwdata[1:0] : 2'h0))
                         | {doneEvent, timeoutEvent};
            irq       <= |(irqStatus & irqEnable);
        end
    end

    // ----------------------------------------
    // APB slave: one wait state, then ready
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clockEnable) begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= 32'h0;
            if (access && !pwrite) begin
                if (hitCfg) begin
                    prdata <= {25'h0, mii_clock_source_sel, mgmt_port_target_sel, outside_phy_strap_flag,
                               outside_mii_port_enable, soft_reset_timeout_flag, soft_reset_trigger};
                end else if (hitStat) begin
                    prdata <= {30'h0, irqStatus};
                end else if (hitEn) begin
                    prdata <= {30'h0, irqEnable};
                end
            end
        end
    end

    // ----------------------------------------
    // Routing outputs
    // ----------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            miiClockRoute     <= `CLKSRC_INTERNAL;
            internalPhyEnable <= 1'b1;
            outsideMiiEnable  <= 1'b0;
            intMdioOut        <= 1'b0;
            intMdc            <= 1'b0;
            extMdioOut        <= 1'b0;
            extMdioOe         <= 1'b0;
            extMdc            <= 1'b0;
            mgmtMdioIn        <= 1'b0;
        end else if (clockEnable) begin
            // Clock route from the clock field only
            miiClockRoute     <= routeCode(mii_clock_source_sel);
            internalPhyEnable <= ~outside_mii_port_enable;
            outsideMiiEnable  <= outside_mii_port_enable;
            if (mgmt_port_target_sel) begin
                intMdioOut <= 1'b0;
                intMdc     <= 1'b0;
                extMdioOut <= mgmtMdioOut;
                extMdioOe  <= mgmtMdioOe;
                extMdc     <= mgmtMdc;
                mgmtMdioIn <= extMdioIn;
            end else begin
                intMdioOut <= mgmtMdioOut & mgmtMdioOe;
                intMdc     <= mgmtMdc;
                extMdioOut <= 1'b0;
                extMdioOe  <= 1'b0;
                extMdc     <= 1'b0;
                mgmtMdioIn <= intMdioIn;
            end
        end
    end

    // External receive and transmit clocks are routed outside this block
    wire unusedExt = extRxClk ^ extTxClk;
endmodule
`default_nettype wire

// *** logic/phy_port_select_regs.vh ***
`ifndef PHY_PORT_SELECT_REGS_VH
`define PHY_PORT_SELECT_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define HWCFG_OFFSET        12'h074
`define IRQ_STATUS_OFFSET   12'h078
`define IRQ_ENABLE_OFFSET   12'h07c
`define IRQ_CLEAR_OFFSET    12'h080

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLKSRC_HI           6
`define CLKSRC_LO           5
`define MGMT_TARGET_BIT     4
`define STRAP_BIT           3
`define EXT_ENABLE_BIT      2
`define TIMEOUT_BIT         1
`define SOFT_RESET_BIT      0

// Interrupt status bits
`define IRQ_TIMEOUT_BIT     0
`define IRQ_RESET_DONE_BIT  1

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define CLKSRC_RESET        2'h0
`define CLKSRC_INTERNAL     2'h0
`define CLKSRC_EXTERNAL     2'h1
`define CLKSRC_DISABLED     2'h2
`define CLKSRC_INTERNAL_ALT 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_PERIOD_NS     10
`define SOFT_RESET_TRIGGER_TIMEOUT_NS     10000
`define SOFT_RESET_TRIGGER_TIMEOUT_CYCLES (`SOFT_RESET_TRIGGER_TIMEOUT_NS / `CLOCK_PERIOD_NS)
`define SOFT_RESET_TRIGGER_PULSE_CYCLES   4
`define ACTIVITY_WINDOW     16

`endif

// *** logic/clock_activity_monitor.v ***
`timescale 1ns/1ns
`default_nettype none
`include "phy_port_select_regs.vh"

// Watches a foreign clock through three flops and reports it running
// while a change has been seen within the last window of cycles.
module clock_activity_monitor #(
    parameter WINDOW = `ACTIVITY_WINDOW
) (
    // System
    input  wire       clock,
    input  wire       rst,
    input  wire       clockEnable,
    // Watched clock and result
    input  wire       watchedClock,
    output reg        running
);
    reg  [2:0]  syncStage;
    reg  [7:0]  idleCount;
    wire        toggled = syncStage[2] ^ syncStage[1];

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            syncStage <= 3'h0;
            idleCount <= 8'h00;
            running   <= 1'b0;
        end else if (clockEnable) begin
            syncStage <= {syncStage[1:0], watchedClock};
            if (toggled) begin
                idleCount <= 8'h00;
                running   <= 1'b1;
            end else if (idleCount >= WINDOW[7:0] - 8'h01) begin
                // Too slow to see as running; a safe underestimate
                running   <= 1'b0;
            end else begin
                idleCount <= idleCount + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/phy_port_select_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module phy_port_select_monitor (
    // System
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        clockEnable,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Routing and management
    input wire logic [1:0]  miiClockRoute,
    input wire logic        internalPhyEnable,
    input wire logic        outsideMiiEnable,
    input wire logic        intMdioOut,
    input wire logic        intMdc,
    input wire logic        extMdioOe,
    input wire logic        extMdc,
    // Soft reset and interrupt
    input wire logic        softResetPulse,
    input wire logic        errorClear,
    input wire logic        irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_ready_wait: assert property (psel && penable && !pready && clockEnable |=> pready)
        else $error("access not answered after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    a_route_legal: assert property (miiClockRoute != 2'h3)
        else $error("clock route code out of range");
    a_port_exclusive: assert property (internalPhyEnable != outsideMiiEnable)
        else $error("port enables not exclusive");
    a_int_mgmt_low: assert property (extMdioOe || extMdc |-> !intMdioOut && !intMdc)
        else $error("internal management active with outside target");
    a_ext_mgmt_idle: assert property (intMdc |-> !extMdioOe && !extMdc)
        else $error("outside management active with inside target");
    a_soft_reset_trigger_width: assert property ($rose(softResetPulse) |-> softResetPulse [*4] ##1 !softResetPulse)
        else $error("soft reset pulse width wrong");
    a_errclr_once: assert property (errorClear |=> !errorClear)
        else $error("error clear longer than one cycle");
    a_errclr_start: assert property ($rose(softResetPulse) |-> errorClear)
        else $error("soft reset started without error clear");
    cover property (pready && pslverr);
    cover property ($rose(softResetPulse));
    cover property (irq);
    cover property (extMdc);
endmodule
bind phy_port_select_config phy_port_select_monitor mon (.*);
`default_nettype wire

// *** tb/phy_side_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module phy_side_model (
    // Bench control
    input wire logic  clocksOn,
    input wire logic  strapHigh,
    // PHY clocks
    output var logic  intRxClk,
    output wire logic intTxClk,
    output wire logic extRxClk,
    output wire logic extTxClk,
    // Management data
    input wire logic  intMdioOut,
    output wire logic intMdioIn,
    input wire logic  extMdioOut,
    input wire logic  extMdioOe,
    output wire logic extMdioIn
);
    // Clocks stand still while the PHY is not operational
    initial begin
        intRxClk = 1'b0;
        forever #20 if (clocksOn) intRxClk = !intRxClk;
    end
    assign intTxClk = !intRxClk;
    assign extRxClk = intRxClk;
    assign extTxClk = intTxClk;
    // Released pin falls to the strap pull level
    assign extMdioIn = extMdioOe ? extMdioOut : strapHigh;
    assign intMdioIn = !intMdioOut;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "phy_port_select_regs.vh"
module tb;
    localparam int TO = 20;
    logic        clock, rst, clockEnable, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d, m;
    logic [32:0] e;
    logic [1:0]  miiClockRoute;
    logic        intRxClk, intTxClk, extRxClk, extTxClk, internalPhyEnable, outsideMiiEnable;
    logic        intMdioIn, intMdioOut, intMdc, extMdioIn, extMdioOut, extMdioOe, extMdc;
    logic        mgmtMdc, mgmtMdioOut, mgmtMdioOe, mgmtMdioIn, softResetPulse, errorClear;
    logic        clocksOn, strapHigh;
    logic [32:0] expQ[$];
    logic [31:0] mskQ[$];
    logic [31:0] seed = 32'hd372;
    int          errCount = 0;
    int          totalChecks = 0;
    int          cycles = 0;

    phy_port_select_config #(.TIMEOUT_CYCLES(TO)) dut (.*);
    phy_side_model phy (.*);

    initial begin
        clock = 1'b0;
        forever #5 clock = !clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [32:0] g, input logic [32:0] x, input string w);
        totalChecks++;
        if (g !== x) begin
            errCount++;
            $display("ERROR %0t %s got %h exp %h", $time, w, g, x);
        end
    endtask

    task automatic giveVerdict;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // APB master; expectation queued for the watcher
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                       input logic [32:0] x, input logic [31:0] k);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        expQ.push_back(x);
        mskQ.push_back(k);
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    always @(posedge clock) begin
        if (pready === 1'b1 && psel === 1'b1) begin
            e = expQ.pop_front();
            m = mskQ.pop_front();
            chk({pslverr, prdata & m}, {e[32], e[31:0] & m}, "apb answer");
        end
    end

    task automatic waitHi(input bit k);
        int n;
        n = 0;
        while ((k ? softResetPulse : irq) !== 1'b1 && n < 4 * TO) begin
            @(posedge clock);
            n++;
        end
        chk(n < 4 * TO, 1, "wait for event");
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            errCount++;
            giveVerdict();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        clockEnable = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        mgmtMdc = 1'b1;
        mgmtMdioOut = 1'b1;
        mgmtMdioOe = 1'b0;
        clocksOn = 1'b1;
        strapHigh = 1'b0;
        for (int r = 0; r < 2; r++) begin
            rst <= 1'b1;
            strapHigh <= (r == 1);
            repeat (12) @(posedge clock);
            rst <= 1'b0;
            repeat (8) @(posedge clock);
            apb(0, `HWCFG_OFFSET, 0, {29'h0, strapHigh, 3'h0}, 32'h7f);
            apb(0, `IRQ_STATUS_OFFSET, 0, 33'h0, 32'h3);
            chk({miiClockRoute, internalPhyEnable, outsideMiiEnable}, 4'h2, "reset ports");
            $display("reset test %0d done", r);
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = {seed[31:7], i[1:0], seed[4:1], 1'b0};
            mgmtMdioOe <= seed[0];
            apb(1, `HWCFG_OFFSET, d, 0, 0);
            apb(0, `HWCFG_OFFSET, 0, {26'h0, d[6:4], 1'b1, d[2], 2'h0}, 32'h7f);
            repeat (4) @(posedge clock);
            chk({miiClockRoute, outsideMiiEnable, internalPhyEnable},
                {(d[6:5] == 2'h3) ? 2'h0 : d[6:5], d[2], !d[2]}, "route");
            chk({intMdc, extMdc, extMdioOe, mgmtMdioIn},
                {!d[4], d[4], d[4] & seed[0], d[4] | !seed[0]}, "mgmt");
        end
        $display("routing test done");
        apb(0, 12'h100, 0, {1'b1, 32'h0}, 32'hffffffff);
        apb(1, 12'h104, 32'h1, {1'b1, 32'h0}, 0);
        $display("unmapped test done");
        // Timeout path: PHY clocks stopped
        clocksOn <= 1'b0;
        repeat (40) @(posedge clock);
        apb(1, `IRQ_ENABLE_OFFSET, 32'h1, 0, 0);
        apb(1, `HWCFG_OFFSET, 32'h0, 0, 0);
        apb(1, `HWCFG_OFFSET, 32'h1, 0, 0);
        apb(1, `HWCFG_OFFSET, 32'h34, 0, 0);
        apb(0, `HWCFG_OFFSET, 0, 33'h1, 32'h1);
        waitHi(0);
        apb(0, `HWCFG_OFFSET, 0, 33'h2, 32'h77);
        apb(0, `IRQ_STATUS_OFFSET, 0, 33'h1, 32'h1);
        apb(1, `IRQ_CLEAR_OFFSET, 32'h1, 0, 0);
        repeat (3) @(posedge clock);
        chk(irq, 0, "irq cleared");
        apb(1, `IRQ_ENABLE_OFFSET, 32'h0, 0, 0);
        apb(1, `HWCFG_OFFSET, 32'h74, 0, 0);
        apb(0, `HWCFG_OFFSET, 0, 33'h7e, 32'h7f);
        $display("timeout test done");
        // Host restores clocks before asking again
        clocksOn <= 1'b1;
        repeat (40) @(posedge clock);
        apb(1, `HWCFG_OFFSET, 32'h75, 0, 0);
        waitHi(1);
        repeat (8) @(posedge clock);
        apb(0, `HWCFG_OFFSET, 0, 33'h8, 32'h7f);
        apb(0, `IRQ_STATUS_OFFSET, 0, 33'h2, 32'h2);
        chk(irq, 0, "irq masked");
        apb(1, `IRQ_ENABLE_OFFSET, 32'h2, 0, 0);
        repeat (3) @(posedge clock);
        chk(irq, 1, "irq raised");
        apb(1, `IRQ_CLEAR_OFFSET, 32'h2, 0, 0);
        repeat (3) @(posedge clock);
        chk(irq, 0, "irq cleared");
        $display("soft reset test done");
        giveVerdict();
    end
endmodule
`default_nettype wire
